// file: shared/scsr_pkg.sv
// Constants, register map and carrier types for the serial control slave with link relay.
// Assumes a 50 MHz core clock; shared by the design and the bench.
package scsr_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int STRAP_WAIT_NS = 1_000_000;
	localparam int STRAP_WAIT_CYC = (STRAP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GLITCH_NS = 50;
	localparam int GLITCH_CYC = (GLITCH_NS / CLK_PERIOD_NS < 1) ? 1 : GLITCH_NS / CLK_PERIOD_NS;
	localparam int SETUP_NS = 50;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Register offsets, fields and reset values
	localparam logic [7:0] OFF_DEV_ID = 8'h00;
	localparam logic [7:0] OFF_GEN_CFG = 8'h02;
	localparam logic [7:0] OFF_PORT_SEL = 8'h4C;
	localparam logic [7:0] OFF_BCC_CFG = 8'h58;
	localparam logic [7:0] OFF_SER_ALIAS = 8'h5C;
	localparam logic [7:0] OFF_ALIAS0 = 8'hF8;
	localparam logic [7:0] OFF_ALIAS1 = 8'hF9;
	localparam int PROXY_EN_BIT = 5;
	localparam int PASS_BIT = 6;
	localparam int RATE_MSB = 2;
	localparam logic [2:0] RATE_2P5M = 3'h0;
	localparam logic [2:0] RATE_50M = 3'h6;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic LINE_IDLE = 1'b1;
	localparam logic LINE_DRIVE = 1'b0;
	// Capability flags advertised over the back channel; value is arbitrary
	localparam logic [7:0] CAPS_BYTE = 8'h01;
	localparam logic [6:0] STRAP_ADDR [8] = '{7'h30, 7'h32, 7'h34, 7'h36, 7'h38, 7'h3A, 7'h3C, 7'h3D};

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000, PH_ADDR = 3'b001, PH_ACK = 3'b010, PH_WRITE = 3'b011,
		PH_SEND = 3'b100, PH_MACK = 3'b101, PH_STRETCH = 3'b110
	} scsr_phase_t;
	typedef enum logic [2:0] {
		LK_START = 3'b000, LK_WRITE = 3'b001, LK_READ = 3'b010, LK_STOP = 3'b011,
		LK_GPIO = 3'b100, LK_CAPS = 3'b101
	} scsr_kind_t;
	typedef struct packed {scsr_kind_t kind; logic port; logic [7:0] data;} scsr_frame_t;
	typedef struct packed {logic valid; logic rate50; scsr_frame_t frame;} scsr_link_tx_t;
	typedef struct packed {logic valid; logic master; logic ack; logic [7:0] data;} scsr_link_rx_t;
	typedef struct packed {logic valid; logic [7:0] data;} scsr_proxy_t;

endpackage

// file: src/scsr_slave.sv
// Serial control slave with back-channel relay: two-wire slave, local registers,
// strap address capture and the link-clock side of the relay.
// Assumes external pull-ups on both bus lines and a far-end link partner on linkClk.
`timescale 1ns/10ps
module scsr_slave import scsr_pkg::*; #(
	parameter int STRAP_WAIT_CYCLES = STRAP_WAIT_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic powerDownPin,
	input wire logic [2:0] addressStrapInput,
	input wire logic modeStrap,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	output logic proxyMasterEnable,
	output logic [1:0] backChannelRate,
	input wire logic linkClk,
	input wire logic linkSrst,
	input wire logic [3:0] gpioIn,
	input wire scsr_link_rx_t linkRx,
	output scsr_link_tx_t linkTx,
	output scsr_proxy_t proxyReq
);

	// ==========================================================
	// State types
	typedef struct packed {
		logic [1:0] pdS;
		logic [1:0] sclS;
		logic [1:0] sdaS;
		logic [2:0] strap1;
		logic [2:0] strap2;
		logic mode1;
		logic mode2;
		logic sclF;
		logic sdaF;
		logic [1:0] sclC;
		logic [1:0] sdaC;
		logic [16:0] waitC;
		logic ready;
		logic [7:0] devId;
		logic [7:0] genCfg;
		logic [7:0] portSel;
		logic [7:0] serAlias;
		logic [7:0] alias0;
		logic [7:0] alias1;
		logic [7:0] bcc0;
		logic [7:0] bcc1;
		scsr_phase_t phase;
		scsr_phase_t after;
		logic [3:0] bitC;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic rw;
		logic relay;
		logic page;
		logic first;
		logic nack;
		logic sdaLow;
		logic sclLow;
		logic lineLvl;
		logic [1:0] setupC;
		logic reqT;
		scsr_frame_t req;
		logic rspA;
		logic rspB;
		logic rspSeen;
		logic waiting;
		logic proxyEn;
		logic [1:0] rate;
	} scsr_ref_t;

	typedef struct packed {
		logic reqA;
		logic reqB;
		logic reqSeen;
		logic rspT;
		logic rspAck;
		logic [7:0] rspData;
		logic busy;
		logic alt;
		logic pmA;
		logic pmB;
		logic [1:0] rA;
		logic [1:0] rB;
		logic [3:0] gA;
		logic [3:0] gB;
		scsr_link_tx_t tx;
		scsr_proxy_t proxy;
	} scsr_lnk_t;

	scsr_ref_t rq_q, rq_d;
	scsr_lnk_t lq_q, lq_d;
	logic sclRise, sclFall, startSeen, stopSeen, wantByte, rspNew, localHit, relayHit;
	logic [6:0] rxAddr;

	// ==========================================================
	// Helpers
	// Filter step: a line change must persist before it is believed
	function automatic logic [2:0] filterStep(input logic raw, input logic filt, input logic [1:0] cnt);
		if (raw == filt)
			return {filt, 2'b00};
		if (cnt == 2'(GLITCH_CYC - 1))
			return {raw, 2'b00};
		return {filt, 2'(cnt + 2'b01)};
	endfunction

	function automatic logic [7:0] regRead(input scsr_ref_t s, input logic [7:0] off, input logic pg);
		unique case (off)
			OFF_DEV_ID: return s.devId;
			OFF_GEN_CFG: return s.genCfg;
			OFF_PORT_SEL: return s.portSel;
			OFF_BCC_CFG: return pg ? s.bcc1 : s.bcc0;
			OFF_SER_ALIAS: return s.serAlias;
			OFF_ALIAS0: return s.alias0;
			OFF_ALIAS1: return s.alias1;
			default: return REG_RST;
		endcase
	endfunction

	// ==========================================================
	// Core-clock next state
	always_comb begin
		rq_d = rq_q;
		wantByte = 1'b0;
		// Two-flop synchronisers on every pin input
		rq_d.pdS = {rq_q.pdS[0], powerDownPin};
		rq_d.sclS = {rq_q.sclS[0], sclIn};
		rq_d.sdaS = {rq_q.sdaS[0], sdaIn};
		rq_d.strap1 = addressStrapInput;
		rq_d.strap2 = rq_q.strap1;
		rq_d.mode1 = modeStrap;
		rq_d.mode2 = rq_q.mode1;
		rq_d.rspA = lq_q.rspT;
		rq_d.rspB = rq_q.rspA;
		{rq_d.sclF, rq_d.sclC} = filterStep(rq_q.sclS[1], rq_q.sclF, rq_q.sclC);
		{rq_d.sdaF, rq_d.sdaC} = filterStep(rq_q.sdaS[1], rq_q.sdaF, rq_q.sdaC);
		sclRise = rq_d.sclF & ~rq_q.sclF;
		sclFall = ~rq_d.sclF & rq_q.sclF;
		startSeen = rq_q.sclF & rq_d.sclF & rq_q.sdaF & ~rq_d.sdaF;
		stopSeen = rq_q.sclF & rq_d.sclF & ~rq_q.sdaF & rq_d.sdaF;
		rspNew = rq_q.rspB != rq_q.rspSeen;
		rxAddr = rq_q.shift[7:1];

		// Address decode: primary, then per-port aliases with direct paging
		localHit = rq_q.ready && (rxAddr == rq_q.devId[7:1] || (rq_q.alias0[7:1] != 7'h00 &&
			rxAddr == rq_q.alias0[7:1]) || (rq_q.alias1[7:1] != 7'h00 && rxAddr == rq_q.alias1[7:1]));
		relayHit = rq_q.ready && rq_q.serAlias[7:1] != 7'h00 && rxAddr == rq_q.serAlias[7:1] &&
			(rq_q.portSel[0] ? rq_q.bcc1[PASS_BIT] : rq_q.bcc0[PASS_BIT]);

		// Strap capture once power-down has been released long enough
		if (!rq_q.ready) begin
			if (rq_q.waitC == 17'(STRAP_WAIT_CYCLES - 1)) begin
				rq_d.ready = 1'b1;
				rq_d.devId = {STRAP_ADDR[rq_q.strap2], 1'b0};
				rq_d.bcc0[RATE_MSB:0] = rq_q.mode2 ? RATE_50M : RATE_2P5M;
				rq_d.bcc1[RATE_MSB:0] = rq_q.mode2 ? RATE_50M : RATE_2P5M;
			end else begin
				rq_d.waitC = 17'(rq_q.waitC + 17'h0_0001);
			end
		end

		// Bus framing: STOP and START override whatever byte was underway
		if (stopSeen) begin
			if (rq_q.relay && !rq_q.waiting) begin
				rq_d.req = '{LK_STOP, rq_q.page, rq_q.shift};
				rq_d.reqT = ~rq_q.reqT;
				rq_d.waiting = 1'b1;
			end
			rq_d.phase = PH_IDLE;
			rq_d.relay = 1'b0;
			rq_d.sdaLow = 1'b0;
			rq_d.sclLow = 1'b0;
		end else if (startSeen) begin
			rq_d.phase = PH_ADDR;
			rq_d.bitC = 4'h0;
			rq_d.sdaLow = 1'b0;
		end else begin
			unique case (rq_q.phase)
				PH_IDLE: begin
					rq_d.bitC = 4'h0;
				end
				PH_ADDR, PH_WRITE: begin
					if (sclRise) begin
						rq_d.shift = {rq_q.shift[6:0], rq_q.sdaF};
						rq_d.bitC = 4'(rq_q.bitC + 4'h1);
					end else if (sclFall && rq_q.bitC == 4'h8) begin
						rq_d.bitC = 4'h0;
						if (rq_q.phase == PH_ADDR && relayHit && !rq_q.waiting) begin
							// Relay a (repeated) START and hold the clock for the answer
							rq_d.relay = 1'b1;
							rq_d.rw = rq_q.shift[0];
							rq_d.page = rq_q.portSel[0];
							rq_d.req = '{LK_START, rq_q.portSel[0], rq_q.shift};
							rq_d.reqT = ~rq_q.reqT;
							rq_d.waiting = 1'b1;
							rq_d.sclLow = 1'b1;
							rq_d.phase = PH_STRETCH;
						end else if (rq_q.phase == PH_ADDR && localHit) begin
							rq_d.relay = 1'b0;
							rq_d.rw = rq_q.shift[0];
							rq_d.page = (rxAddr == rq_q.alias1[7:1]) ? 1'b1 :
								(rxAddr == rq_q.alias0[7:1]) ? 1'b0 : rq_q.portSel[0];
							rq_d.first = ~rq_q.shift[0];
							rq_d.nack = 1'b0;
							rq_d.sdaLow = 1'b1;
							rq_d.phase = PH_ACK;
						end else if (rq_q.phase == PH_ADDR) begin
							rq_d.relay = 1'b0;
							rq_d.phase = PH_IDLE;
						end else if (rq_q.relay) begin
							rq_d.req = '{LK_WRITE, rq_q.page, rq_q.shift};
							rq_d.reqT = ~rq_q.reqT;
							rq_d.waiting = 1'b1;
							rq_d.sclLow = 1'b1;
							rq_d.phase = PH_STRETCH;
						end else begin
							// Local write: offset first, then data with auto-increment
							if (rq_q.first) begin
								rq_d.ptr = rq_q.shift;
								rq_d.first = 1'b0;
							end else begin
								unique case (rq_q.ptr)
									OFF_DEV_ID: rq_d.devId = rq_q.shift;
									OFF_GEN_CFG: rq_d.genCfg = rq_q.shift;
									OFF_PORT_SEL: rq_d.portSel = rq_q.shift;
									OFF_BCC_CFG: begin
										if (rq_q.page)
											rq_d.bcc1 = rq_q.shift;
										else
											rq_d.bcc0 = rq_q.shift;
									end
									OFF_SER_ALIAS: rq_d.serAlias = rq_q.shift;
									OFF_ALIAS0: rq_d.alias0 = rq_q.shift;
									OFF_ALIAS1: rq_d.alias1 = rq_q.shift;
									default: rq_d.ptr = rq_q.ptr;
								endcase
								rq_d.ptr = 8'(rq_q.ptr + 8'h01);
							end
							rq_d.sdaLow = 1'b1;
							rq_d.phase = PH_ACK;
						end
					end
				end
				PH_ACK: begin
					if (sclFall) begin
						rq_d.sdaLow = 1'b0;
						if (rq_q.nack)
							rq_d.phase = PH_IDLE;
						else if (rq_q.rw)
							wantByte = 1'b1;
						else
							rq_d.phase = PH_WRITE;
					end
				end
				PH_SEND: begin
					if (sclFall) begin
						if (rq_q.bitC == 4'h7) begin
							rq_d.sdaLow = 1'b0;
							rq_d.phase = PH_MACK;
						end else begin
							rq_d.sdaLow = ~rq_q.shift[6];
							rq_d.shift = {rq_q.shift[6:0], 1'b0};
							rq_d.bitC = 4'(rq_q.bitC + 4'h1);
						end
					end
				end
				PH_MACK: begin
					// Master's answer decides whether another byte follows
					if (sclRise)
						rq_d.nack = rq_q.sdaF;
					else if (sclFall && rq_q.nack)
						rq_d.phase = PH_IDLE;
					else if (sclFall)
						wantByte = 1'b1;
				end
				PH_STRETCH: begin
					// Data is settled before the clock is let go
					if (!rq_q.waiting && !rspNew) begin
						if (rq_q.setupC == 2'b00) begin
							rq_d.sclLow = 1'b0;
							rq_d.phase = rq_q.after;
						end else begin
							rq_d.setupC = 2'(rq_q.setupC - 2'b01);
						end
					end
				end
			endcase
		end

		// Next read byte, from the register file or across the link
		if (wantByte) begin
			rq_d.bitC = 4'h0;
			if (rq_q.relay) begin
				rq_d.req = '{LK_READ, rq_q.page, rq_q.shift};
				rq_d.reqT = ~rq_q.reqT;
				rq_d.waiting = 1'b1;
				rq_d.sclLow = 1'b1;
				rq_d.phase = PH_STRETCH;
			end else begin
				rq_d.shift = regRead(rq_q, rq_q.ptr, rq_q.page);
				rq_d.sdaLow = ~rq_d.shift[7];
				rq_d.ptr = 8'(rq_q.ptr + 8'h01);
				rq_d.phase = PH_SEND;
			end
		end

		// Remote answer: load it onto the bus while the clock is still held
		if (rspNew) begin
			rq_d.rspSeen = rq_q.rspB;
			rq_d.waiting = 1'b0;
			if (rq_q.phase == PH_STRETCH && rq_d.phase == PH_STRETCH) begin
				rq_d.setupC = 2'(SETUP_CYC);
				if (rq_q.req.kind == LK_READ) begin
					rq_d.shift = lq_q.rspData;
					rq_d.sdaLow = ~lq_q.rspData[7];
					rq_d.after = PH_SEND;
				end else begin
					rq_d.sdaLow = lq_q.rspAck;
					rq_d.nack = ~lq_q.rspAck;
					rq_d.after = PH_ACK;
				end
			end
		end

		rq_d.proxyEn = rq_q.genCfg[PROXY_EN_BIT];
		rq_d.rate[0] = rq_q.bcc0[RATE_MSB:0] == RATE_50M;
		rq_d.rate[1] = rq_q.bcc1[RATE_MSB:0] == RATE_50M;
		rq_d.lineLvl = LINE_DRIVE;

		// Reset, or held inactive while power-down is asserted
		if (srst || !rq_q.pdS[1]) begin
			rq_d = '0;
			rq_d.pdS = srst ? 2'b00 : {rq_q.pdS[0], powerDownPin};
			rq_d.sclS = {2{LINE_IDLE}};
			rq_d.sdaS = {2{LINE_IDLE}};
			rq_d.sclF = LINE_IDLE;
			rq_d.sdaF = LINE_IDLE;
			rq_d.devId = REG_RST;
			rq_d.genCfg = REG_RST;
			rq_d.portSel = REG_RST;
			rq_d.serAlias = REG_RST;
			rq_d.alias0 = REG_RST;
			rq_d.alias1 = REG_RST;
			rq_d.bcc0 = REG_RST;
			rq_d.bcc1 = REG_RST;
			rq_d.phase = PH_IDLE;
			rq_d.after = PH_IDLE;
			rq_d.lineLvl = LINE_DRIVE;
		end
	end

	// Core-clock state register
	always_ff @(posedge ref_clk) begin
		rq_q <= rq_d;
	end

	// ==========================================================
	// Link-clock next state
	always_comb begin
		lq_d = lq_q;
		lq_d.reqA = rq_q.reqT;
		lq_d.reqB = lq_q.reqA;
		lq_d.pmA = rq_q.proxyEn;
		lq_d.pmB = lq_q.pmA;
		lq_d.rA = rq_q.rate;
		lq_d.rB = lq_q.rA;
		lq_d.gA = gpioIn;
		lq_d.gB = lq_q.gA;
		lq_d.proxy.valid = 1'b0;

		// Forward a new request; fill idle slots with pin states and capabilities
		if (lq_q.reqB != lq_q.reqSeen && !lq_q.busy) begin
			lq_d.reqSeen = lq_q.reqB;
			lq_d.tx = '{1'b1, lq_q.rB[rq_q.req.port], rq_q.req};
			if (rq_q.req.kind == LK_STOP)
				lq_d.rspT = ~lq_q.rspT;
			else
				lq_d.busy = 1'b1;
		end else begin
			lq_d.alt = ~lq_q.alt;
			lq_d.tx.valid = 1'b1;
			lq_d.tx.rate50 = lq_q.rB[0];
			lq_d.tx.frame = lq_q.alt ? '{LK_CAPS, 1'b0, CAPS_BYTE} : '{LK_GPIO, 1'b0, {4'h0, lq_q.gB}};
		end

		// Far-end traffic: answers to relayed accesses, or remote master requests
		if (linkRx.valid && linkRx.master) begin
			lq_d.proxy = '{lq_q.pmB, linkRx.data};
		end else if (linkRx.valid && lq_q.busy) begin
			lq_d.rspAck = linkRx.ack;
			lq_d.rspData = linkRx.data;
			lq_d.rspT = ~lq_q.rspT;
			lq_d.busy = 1'b0;
		end

		if (linkSrst)
			lq_d = '0;
	end

	// Link-clock state register
	always_ff @(posedge linkClk) begin
		lq_q <= lq_d;
	end

	// ==========================================================
	// Outputs, all from flops
	assign sclOut = rq_q.lineLvl;
	assign sclOe = rq_q.sclLow;
	assign sdaOut = rq_q.lineLvl;
	assign sdaOe = rq_q.sdaLow;
	assign proxyMasterEnable = rq_q.proxyEn;
	assign backChannelRate = rq_q.rate;
	assign linkTx = lq_q.tx;
	assign proxyReq = lq_q.proxy;

endmodule // scsr_slave

// file: testbench/scsr_slave_chk.sv
// Checker for the serial control slave: bus line discipline, strap wait, stretching, proxy gating.
// Assumes it is bound into scsr_slave and sees the resolved bus levels on sclIn and sdaIn.
`timescale 1ns/10ps
module scsr_slave_chk import scsr_pkg::*; #(
	parameter int STRAP_WAIT_CYCLES = STRAP_WAIT_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic powerDownPin,
	input wire logic sclIn,
	input wire logic sclOut,
	input wire logic sclOe,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic proxyMasterEnable,
	input wire logic linkClk,
	input wire logic linkSrst,
	input wire scsr_proxy_t proxyReq
);
	// ==========================================================
	// Cycles since the core side left reset or power-down
	logic [31:0] upCnt_q;
	logic [31:0] upCnt_d;
	// Saturates so a long run never wraps back into the wait window
	always_comb begin
		upCnt_d = upCnt_q;
		if (srst || !powerDownPin) begin
			upCnt_d = '0;
		end else if (upCnt_q != 32'hFFFF_FFFF) begin
			upCnt_d = upCnt_q + 32'h0000_0001;
		end
	end
	always_ff @(posedge ref_clk) begin
		upCnt_q <= upCnt_d;
	end

	// ==========================================================
	// Assertions
	out_low_a: assert property (@(posedge ref_clk) disable iff (srst)
		sclOut == 1'b0 && sdaOut == 1'b0) else $error("Bus line driven high");
	strap_wait_a: assert property (@(posedge ref_clk) disable iff (srst)
		upCnt_q < STRAP_WAIT_CYCLES |-> !sdaOe && !sclOe) else $error("Answered before strap wait");
	pd_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
		!powerDownPin [*4] |-> !sdaOe && !sclOe) else $error("Active in power-down");
	sda_edge_a: assert property (@(posedge ref_clk) disable iff (srst)
		$changed(sdaOe) |-> !sclIn) else $error("Data moved while clock high");
	stop_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
		sclIn && $rose(sdaIn) |=> !sdaOe [*8]) else $error("Drive after stop");
	stretch_start_a: assert property (@(posedge ref_clk) disable iff (srst)
		$rose(sclOe) |-> !sclIn) else $error("Stretch began with clock high");
	stretch_bound_a: assert property (@(posedge ref_clk) disable iff (srst)
		$rose(sclOe) |-> ##[1:1000] !sclOe) else $error("Stretch never ended");
	stretch_setup_a: assert property (@(posedge ref_clk) disable iff (srst)
		$fell(sclOe) |-> $stable(sdaOe) && sdaOe == $past(sdaOe, 2)) else $error("No data setup");
	proxy_gate_a: assert property (@(posedge linkClk) disable iff (linkSrst)
		proxyReq.valid |-> proxyMasterEnable) else $error("Proxy request while disabled");
endmodule // scsr_slave_chk

bind scsr_slave scsr_slave_chk #(.STRAP_WAIT_CYCLES(STRAP_WAIT_CYCLES)) u_chk (
	.ref_clk(ref_clk), .srst(srst), .powerDownPin(powerDownPin), .sclIn(sclIn), .sclOut(sclOut),
	.sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .proxyMasterEnable(proxyMasterEnable),
	.linkClk(linkClk), .linkSrst(linkSrst), .proxyReq(proxyReq));

// file: testbench/scsr_host_model.sv
// Host bus master model: start, stop, byte write and read at a 1 MHz bit rate.
// Assumes the bench resolves both open-drain wires with pull-ups and feeds them back.
`timescale 1ns/10ps
module scsr_host_model (
	input wire logic ref_clk,
	input wire logic scl,
	input wire logic sda,
	output logic sclLow,
	output logic sdaLow
);
	// ==========================================================
	// Bit level
	initial begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end
	// Moves land just after a core edge, never on it
	task automatic hw(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// One clock pulse of 50 core cycles; waits while the slave stretches
	task automatic bitx(input logic b, output logic r);
		int n;
		sdaLow = !b;
		hw(12);
		sclLow = 1'b0;
		n = 0;
		while (!scl && n < 5000) begin
			hw(1);
			n++;
		end
		hw(12);
		r = sda;
		hw(13);
		sclLow = 1'b1;
		hw(13);
	endtask

	// ==========================================================
	// Framing, also usable as repeated start
	task automatic start;
		sdaLow = 1'b0;
		hw(12);
		sclLow = 1'b0;
		hw(25);
		sdaLow = 1'b1;
		hw(25);
		sclLow = 1'b1;
		hw(13);
	endtask
	task automatic stop;
		sdaLow = 1'b1;
		hw(12);
		sclLow = 1'b0;
		hw(25);
		sdaLow = 1'b0;
		hw(25);
	endtask
	// Byte out MSB first, ack is the slave pulling data low
	task automatic wb(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	// Byte in; last byte is refused so the slave lets go
	task automatic rb(output logic [7:0] d, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(last, r);
	endtask
endmodule // scsr_host_model

// file: testbench/tb_serial_control_slave_with_link_relay.sv
// Self-checking bench: strap addresses, aliases, relay with stretching, proxy gate, link frames.
// Assumes scsr_slave, its checker and the host model; the bench answers the link itself.
`timescale 1ns/10ps
module tb_serial_control_slave_with_link_relay;
	import scsr_pkg::*;
	// ==========================================================
	// Signals and clocks
	logic ref_clk = 1'b0;
	logic linkClk = 1'b0;
	logic srst, powerDownPin, modeStrap, linkSrst, sclOut, sclOe, sdaOut, sdaOe, proxyMasterEnable;
	logic sclLowH, sdaLowH, proxyKick, sawStretch, sawGpio, sawCaps, lastRate;
	logic [2:0] addressStrapInput;
	logic [1:0] backChannelRate;
	logic [3:0] gpioIn;
	logic [7:0] lastWr, proxyCnt, proxyData;
	scsr_link_rx_t linkRx;
	scsr_link_tx_t linkTx, prevTx;
	scsr_proxy_t proxyReq;
	int ansCnt = 0;
	int bad_count = 0;
	int check_count = 0;
	wire scl = !(sclLowH || sclOe);
	wire sda = !(sdaLowH || sdaOe);
	always #10 ref_clk = ~ref_clk;
	// Link clock offset so the two domains never line up
	initial begin
		#7;
		forever #16 linkClk = ~linkClk;
	end

	scsr_slave #(.STRAP_WAIT_CYCLES(20)) DUT (
		.ref_clk(ref_clk), .srst(srst), .powerDownPin(powerDownPin), .addressStrapInput(addressStrapInput),
		.modeStrap(modeStrap), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .proxyMasterEnable(proxyMasterEnable), .backChannelRate(backChannelRate),
		.linkClk(linkClk), .linkSrst(linkSrst), .gpioIn(gpioIn), .linkRx(linkRx), .linkTx(linkTx),
		.proxyReq(proxyReq));
	scsr_host_model H (.ref_clk(ref_clk), .scl(scl), .sda(sda), .sclLow(sclLowH), .sdaLow(sdaLowH));

	// ==========================================================
	// Far end of the link: answers each new start, write or read request a few cycles late
	always @(posedge linkClk) begin
		prevTx <= linkTx;
		linkRx <= '0;
		if (linkTx.valid && linkTx != prevTx && linkTx.frame.kind inside {LK_START, LK_WRITE, LK_READ}) begin
			ansCnt <= 4;
		end else if (ansCnt != 0) begin
			ansCnt <= ansCnt - 1;
			if (ansCnt == 1) linkRx <= '{valid: 1'b1, master: 1'b0, ack: 1'b1, data: 8'hA5};
		end
		if (proxyKick) linkRx <= '{valid: 1'b1, master: 1'b1, ack: 1'b0, data: 8'h3C};
		if (linkTx.valid && linkTx.frame.kind == LK_GPIO && linkTx.frame.data[3:0] === gpioIn) sawGpio = 1'b1;
		if (linkTx.valid && linkTx.frame.kind == LK_CAPS && linkTx.frame.data === CAPS_BYTE) sawCaps = 1'b1;
		if (linkTx.valid && linkTx.frame.kind == LK_WRITE) begin
			lastWr = linkTx.frame.data;
			lastRate = linkTx.rate50;
		end
		if (proxyReq.valid) begin
			proxyCnt = proxyCnt + 8'h01;
			proxyData = proxyReq.data;
		end
	end
	// Any clock held low by the slave
	always @(posedge ref_clk) if (sclOe) sawStretch = 1'b1;

	// ==========================================================
	// Shared tasks
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wreg(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] d0, input logic [7:0] d1,
			input logic two);
		logic a;
		H.start;
		H.wb({dev, 1'b0}, a);
		chk(16'(a), 16'h0001);
		H.wb(off, a);
		chk(16'(a), 16'h0001);
		H.wb(d0, a);
		chk(16'(a), 16'h0001);
		if (two) H.wb(d1, a);
		H.stop;
	endtask
	task rreg(input logic [6:0] dev, input logic [7:0] off, output logic [7:0] d);
		logic a;
		H.start;
		H.wb({dev, 1'b0}, a);
		H.wb(off, a);
		H.start;
		H.wb({dev, 1'b1}, a);
		chk(16'(a), 16'h0001);
		H.rb(d, 1'b1);
		H.stop;
	endtask
	task end_of_test;
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task t_strap;
		logic [7:0] d;
		for (int s = 0; s < 8; s++) begin
			addressStrapInput = 3'(s);
			modeStrap = s[0];
			powerDownPin = 1'b0;
			H.hw(5);
			powerDownPin = 1'b1;
			H.hw(40);
			rreg(STRAP_ADDR[s], OFF_DEV_ID, d);
			chk(16'(d), {8'h00, STRAP_ADDR[s], 1'b0});
		end
		chk(16'(backChannelRate), 16'h0003);
	endtask
	task t_nack;
		logic a;
		H.start;
		H.wb(8'h62, a);
		chk(16'(a), 16'h0000);
		H.stop;
		// Clock pulses with no start in front must be ignored
		H.sclLow = 1'b1;
		H.hw(13);
		H.wb(8'h7A, a);
		chk(16'(a), 16'h0000);
		H.stop;
	endtask
	task t_alias;
		logic [7:0] d;
		sawStretch = 1'b0;
		wreg(7'h3D, OFF_ALIAS0, 8'h50, 8'h52, 1'b1);
		rreg(7'h28, OFF_ALIAS0, d);
		chk(16'(d), 16'h0050);
		rreg(7'h29, OFF_ALIAS1, d);
		chk(16'(d), 16'h0052);
		chk(16'(sawStretch), 16'h0000);
	endtask
	task t_relay;
		logic a;
		logic [7:0] d;
		wreg(7'h3D, OFF_PORT_SEL, 8'h00, 8'h00, 1'b0);
		wreg(7'h3D, OFF_SER_ALIAS, 8'h40, 8'h00, 1'b0);
		wreg(7'h3D, OFF_BCC_CFG, 8'h00, 8'h00, 1'b0);
		H.start;
		H.wb(8'h40, a);
		chk(16'(a), 16'h0000);
		H.stop;
		chk(16'(backChannelRate), 16'h0002);
		// Pass-through on, port 0 rate overridden to the fast code
		wreg(7'h3D, OFF_BCC_CFG, 8'h46, 8'h00, 1'b0);
		// Far end answers from reset, so relayed accesses complete
		sawStretch = 1'b0;
		H.start;
		H.wb(8'h40, a);
		chk(16'(a), 16'h0001);
		H.wb(8'h11, a);
		chk({6'h00, lastRate, a, lastWr}, 16'h0311);
		H.start;
		H.wb(8'h41, a);
		H.rb(d, 1'b1);
		chk({7'h00, a, d}, 16'h01A5);
		H.stop;
		chk(16'(sawStretch), 16'h0001);
	endtask
	task kick;
		@(posedge linkClk);
		#1 proxyKick = 1'b1;
		@(posedge linkClk);
		#1 proxyKick = 1'b0;
	endtask
	task t_proxy;
		proxyCnt = 8'h00;
		kick;
		H.hw(20);
		chk(16'(proxyCnt), 16'h0000);
		wreg(7'h3D, OFF_GEN_CFG, 8'h20, 8'h00, 1'b0);
		chk(16'(proxyMasterEnable), 16'h0001);
		kick;
		H.hw(20);
		chk({proxyCnt, proxyData}, 16'h013C);
	endtask
	// Mid-run reset of both domains with new straps: registers cleared, strap taken again
	task t_reset;
		logic [7:0] d;
		srst = 1'b1;
		linkSrst = 1'b1;
		modeStrap = 1'b0;
		addressStrapInput = 3'h2;
		gpioIn = 4'h3;
		H.hw(5);
		srst = 1'b0;
		linkSrst = 1'b0;
		chk(16'(proxyMasterEnable), 16'h0000);
		H.hw(40);
		rreg(STRAP_ADDR[2], OFF_DEV_ID, d);
		chk({6'h00, backChannelRate, d}, {8'h00, STRAP_ADDR[2], 1'b0});
	endtask
	task t_link;
		sawGpio = 1'b0;
		gpioIn = 4'hA;
		H.hw(400);
		chk({7'h00, sawGpio, 7'h00, sawCaps}, 16'h0101);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		srst = 1'b1;
		linkSrst = 1'b1;
		powerDownPin = 1'b1;
		modeStrap = 1'b1;
		addressStrapInput = 3'h0;
		gpioIn = 4'h5;
		linkRx = '0;
		proxyKick = 1'b0;
		sawCaps = 1'b0;
		sawGpio = 1'b0;
		lastWr = 8'h00;
		lastRate = 1'b0;
		H.hw(5);
		srst = 1'b0;
		linkSrst = 1'b0;
		t_strap;
		t_nack;
		t_alias;
		t_relay;
		t_proxy;
		t_reset;
		t_link;
		end_of_test;
	end
	// Over twice the expected run length, still well under the cycle budget
	initial begin
		#1_800_000;
		bad_count++;
		end_of_test;
	end
endmodule // tb_serial_control_slave_with_link_relay
